// ---- core/acc_pkg.sv ----
// Shared constants for the converter configuration, clock and channel control block.
package acc_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] ADR_CONTROL  = 8'h00;  // Module on, go and continuous bits.
  localparam logic [7:0] ADR_CHANNEL  = 8'h04;  // Input channel selector.
  localparam logic [7:0] ADR_REFSEL   = 8'h08;  // Positive and negative reference selectors.
  localparam logic [7:0] ADR_CLKSEL   = 8'h0C;  // Divider select and clock source select.
  localparam logic [7:0] ADR_FLAGS    = 8'h10;  // Peripheral flag register.
  localparam logic [7:0] ADR_ENABLES  = 8'h14;  // Peripheral enable register.
  localparam logic [7:0] ADR_STATUS   = 8'h18;  // Read-only conversion status.

  // Field positions inside the control register.
  localparam int CTL_ON_BIT   = 0;  // Converter module on.
  localparam int CTL_GO_BIT   = 1;  // Conversion go bit.
  localparam int CTL_CONT_BIT = 2;  // Continuous conversion mode.

  // Field positions inside the reference register.
  localparam int REF_POS_LSB  = 0;  // Three-bit positive reference code.
  localparam int REF_NEG_BIT  = 4;  // Negative reference select.

  // Field positions inside the clock register.
  localparam int CLK_DIV_LSB  = 0;  // Six-bit divider code.
  localparam int CLK_SRC_BIT  = 7;  // Clock source select, 1 picks the RC clock.

  // Flag and enable bit positions, and status fields.
  localparam int FLG_DONE_BIT = 0;  // Conversion done flag.
  localparam int ENA_IRQ_BIT  = 0;  // Conversion interrupt enable.
  localparam int STS_BUSY_BIT = 0;  // Conversion in progress.
  localparam int STS_HCNT_LSB = 1;  // Half-period count of the running conversion.
  localparam int STS_CSRC_BIT = 8;  // Clock source actually in use.

  // Positive reference codes.
  localparam logic [2:0] PREF_SUPPLY  = 3'h0;  // Supply rail.
  localparam logic [2:0] PREF_EXTPIN  = 3'h1;  // External reference pin.
  localparam logic [2:0] PREF_FVR1    = 3'h2;  // Fixed reference at 1.024V.
  localparam logic [2:0] PREF_FVR2    = 3'h3;  // Fixed reference at 2.048V.
  localparam logic [2:0] PREF_FVR4    = 3'h4;  // Fixed reference at 4.096V.
  localparam int         NUM_PREF     = 5;     // Number of positive reference sources.

  // Internal channel codes.
  localparam logic [5:0] CH_FVR       = 6'h3F;  // Fixed voltage reference.
  localparam logic [5:0] CH_DAC       = 6'h3E;  // On-chip DAC output.
  localparam logic [5:0] CH_TEMP      = 6'h3D;  // Temperature indicator.
  localparam logic [5:0] CH_GND       = 6'h3C;  // Analog ground.
  localparam int         NUM_INTERNAL = 4;      // Internal sources on top of the pins.
  localparam int         NUM_PINS_MAX = 35;     // Pin codes 000000 to 100010.

  // Reset values.
  localparam logic [5:0] RST_CHANNEL  = 6'h00;
  localparam logic [2:0] RST_PREF     = 3'h0;
  localparam logic [5:0] RST_CDIV     = 6'h00;
  localparam logic       RST_CSRC     = 1'b0;

  // Conversion timing: 11.5 bit periods counted in half periods.
  localparam logic [4:0] HALF_PERIODS = 5'h17;

endpackage

// ---- core/acc_clk_gen.sv ----
// Converter bit clock enable generator: divided system clock or synchronised RC clock.
`timescale 1ns/100ps
`default_nettype none

module acc_clk_gen (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // RC oscillator pin, asynchronous to clk_i.
  input  wire logic       rc_clk_i,
  // Clock selection, already latched by the caller.
  input  wire logic       src_rc_i,
  input  wire logic [5:0] div_code_i,
  // One-cycle pulse on every half period of the converter clock.
  output logic            half_tick_o
);

  // All state in one record.
  typedef struct packed {
    logic       sync1;  // First synchroniser stage.
    logic       sync2;  // Second synchroniser stage.
    logic       last;   // Previous value of the second stage.
    logic [5:0] cnt;    // System clock divider count.
    logic       tick;   // Registered half-period pulse.
  } acc_clk_state_t;

  acc_clk_state_t st_ff;
  acc_clk_state_t nxt_st;

  // Next-state logic. Each RC edge marks a half period; the divider
  // marks one every code+1 system cycles, so a full period is 2*(code+1).
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = rc_clk_i;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.last  = st_ff.sync2;
    nxt_st.tick  = 1'b0;
    if (src_rc_i) begin
      // The RC path ignores the system rate entirely.
      nxt_st.cnt  = 6'h00;
      nxt_st.tick = st_ff.sync2 ^ st_ff.last;
    end else if (st_ff.cnt >= div_code_i) begin
      // Divider wrap: even divisor 2*(code+1) from 2 to 128; tracks the system rate.
      nxt_st.cnt  = 6'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 6'h01;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign half_tick_o = st_ff.tick;

endmodule

`default_nettype wire

// ---- core/acc_top.sv ----
// Converter configuration, clock selection, channel routing and conversion timing.
// Function
// - Route exactly the selected channel to sampler.
// - Top four codes pick FIXED_VOLTAGE_REFERENCE, DAC, temperature, ground.
// - Low codes select pins in port order.
// - Reserved codes connect no source at all.
// - Positive reference picks one of five sources.
// - One bit picks negative pin or ground.
// - Source bit picks RC clock or divided clock.
// - Divider code gives even divisors 2 to 128.
// - Conversion lasts 11.5 bit periods.
// - Control logic runs on selected converter clock.
// - Divided clock follows system clock rate.
// - Completion sets flag; irq needs enable.
// - Flag stays until software writes zero.
// - Flag set on every completion regardless.
// - Runs only when on; go starts.
// - Completion clears go unless continuous mode or a same-cycle control write.
`timescale 1ns/100ps
`default_nettype none

module acc_top #(
  parameter int NUM_PINS = 35  // Analog pins bonded out; 24 on the small package.
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone classic slave.
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // RC oscillator pin.
  input  wire logic                 rc_clk_i,
  // Analog control towards the multiplexer, references and sampler.
  output logic [NUM_PINS+3:0]       sampler_source_o,
  output logic [4:0]                pos_ref_sel_o,
  output logic                      neg_ref_ext_o,
  output logic                      sample_hold_o,
  output logic                      bit_strobe_o,
  output logic [3:0]                bit_index_o,
  output logic                      conv_done_o,
  // Interrupt request, flag gated by enable.
  output logic                      conv_irq_o
);

  localparam int NSRC = NUM_PINS + acc_pkg::NUM_INTERNAL;  // Width of the source select.

  // All state of the block in one record.
  typedef struct packed {
    logic                on;      // Converter module on.
    logic                go;      // Conversion go bit.
    logic                cont;    // Continuous conversion mode.
    logic [5:0]          chan;    // Channel selector as written.
    logic [2:0]          pref;    // Positive reference code as written.
    logic                nref;    // Negative reference select as written.
    logic                csrc;    // Clock source select as written.
    logic [5:0]          cdiv;    // Divider code as written.
    logic                flag;    // Conversion done flag.
    logic                ien;     // Conversion interrupt enable.
    logic [NSRC-1:0]     a_src;   // Source select in effect.
    logic [4:0]          a_pref;  // Positive reference in effect, one-hot.
    logic                a_nref;  // Negative reference in effect.
    logic                a_csrc;  // Clock source in effect.
    logic [5:0]          a_cdiv;  // Divider code in effect.
    logic                busy;    // Conversion running.
    logic [4:0]          hcnt;    // Half periods elapsed in this conversion.
    logic                strobe;  // One bit resolved this cycle.
    logic                done;    // Completion pulse.
    logic                ack;     // Wishbone acknowledge.
    logic [31:0]         rdat;    // Wishbone read data.
  } acc_state_t;

  acc_state_t st_ff;
  acc_state_t nxt_st;
  logic       half_tick;  // Half-period enable of the converter clock.

  // Decode a channel code to a one-hot source select; reserved and
  // unbonded pin codes give all zeros so nothing reaches the sampler.
  function automatic logic [NSRC-1:0] decode_channel(input logic [5:0] code);
    logic [NSRC-1:0] sel;
    sel = '0;
    if (code == acc_pkg::CH_FVR) begin
      sel[NUM_PINS] = 1'b1;
    end else if (code == acc_pkg::CH_DAC) begin
      sel[NUM_PINS+1] = 1'b1;
    end else if (code == acc_pkg::CH_TEMP) begin
      sel[NUM_PINS+2] = 1'b1;
    end else if (code == acc_pkg::CH_GND) begin
      sel[NUM_PINS+3] = 1'b1;
    end else if (int'(code) < NUM_PINS) begin
      sel[code] = 1'b1;
    end
    // Every other code leaves the select empty.
    return sel;
  endfunction

  // Decode the positive reference code to one-hot; reserved codes fall back to the supply.
  function automatic logic [4:0] decode_pref(input logic [2:0] code);
    logic [4:0] sel;
    sel = 5'h01;
    unique case (code)
      acc_pkg::PREF_EXTPIN: sel = 5'h02;
      acc_pkg::PREF_FVR1:   sel = 5'h04;
      acc_pkg::PREF_FVR2:   sel = 5'h08;
      acc_pkg::PREF_FVR4:   sel = 5'h10;
      default:              sel = 5'h01;
    endcase
    return sel;
  endfunction

  // Converter clock enable from the clock selection in effect.
  acc_clk_gen u_clk_gen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .rc_clk_i   (rc_clk_i),
    .src_rc_i   (st_ff.a_csrc),
    .div_code_i (st_ff.a_cdiv),
    .half_tick_o(half_tick)
  );

  // Next-state logic: bus access, setting transfer, conversion timing.
  always_comb begin
    logic bus_req;
    logic bus_wr;
    bus_req       = wb_cyc_i && wb_stb_i;
    bus_wr        = bus_req && wb_we_i && st_ff.ack && wb_sel_i[0];
    nxt_st        = st_ff;
    nxt_st.strobe = 1'b0;
    nxt_st.done   = 1'b0;
    nxt_st.ack    = bus_req && !st_ff.ack;

    // Read data is captured on the request edge and shown with ack.
    nxt_st.rdat = 32'h0000_0000;
    unique case (wb_adr_i)
      acc_pkg::ADR_CONTROL: begin
        nxt_st.rdat[acc_pkg::CTL_ON_BIT]   = st_ff.on;
        nxt_st.rdat[acc_pkg::CTL_GO_BIT]   = st_ff.go;
        nxt_st.rdat[acc_pkg::CTL_CONT_BIT] = st_ff.cont;
      end
      acc_pkg::ADR_CHANNEL: nxt_st.rdat[5:0] = st_ff.chan;
      acc_pkg::ADR_REFSEL: begin
        nxt_st.rdat[acc_pkg::REF_POS_LSB +: 3] = st_ff.pref;
        nxt_st.rdat[acc_pkg::REF_NEG_BIT]      = st_ff.nref;
      end
      acc_pkg::ADR_CLKSEL: begin
        nxt_st.rdat[acc_pkg::CLK_DIV_LSB +: 6] = st_ff.cdiv;
        nxt_st.rdat[acc_pkg::CLK_SRC_BIT]      = st_ff.csrc;
      end
      acc_pkg::ADR_FLAGS:   nxt_st.rdat[acc_pkg::FLG_DONE_BIT] = st_ff.flag;
      acc_pkg::ADR_ENABLES: nxt_st.rdat[acc_pkg::ENA_IRQ_BIT]  = st_ff.ien;
      acc_pkg::ADR_STATUS: begin
        nxt_st.rdat[acc_pkg::STS_BUSY_BIT]      = st_ff.busy;
        nxt_st.rdat[acc_pkg::STS_HCNT_LSB +: 5] = st_ff.hcnt;
        nxt_st.rdat[acc_pkg::STS_CSRC_BIT]      = st_ff.a_csrc;
      end
      default: nxt_st.rdat = 32'h0000_0000;  // Unmapped reads return zero.
    endcase

    // Writes take effect on the edge where ack is high; all fields sit in byte 0.
    if (bus_wr) begin
      unique case (wb_adr_i)
        acc_pkg::ADR_CONTROL: begin
          nxt_st.on   = wb_dat_i[acc_pkg::CTL_ON_BIT];
          nxt_st.cont = wb_dat_i[acc_pkg::CTL_CONT_BIT];
          // Go can only be set while the module is on.
          nxt_st.go   = wb_dat_i[acc_pkg::CTL_GO_BIT] && wb_dat_i[acc_pkg::CTL_ON_BIT];
        end
        acc_pkg::ADR_CHANNEL: nxt_st.chan = wb_dat_i[5:0];
        acc_pkg::ADR_REFSEL: begin
          nxt_st.pref = wb_dat_i[acc_pkg::REF_POS_LSB +: 3];
          nxt_st.nref = wb_dat_i[acc_pkg::REF_NEG_BIT];
        end
        acc_pkg::ADR_CLKSEL: begin
          nxt_st.cdiv = wb_dat_i[acc_pkg::CLK_DIV_LSB +: 6];
          nxt_st.csrc = wb_dat_i[acc_pkg::CLK_SRC_BIT];
        end
        acc_pkg::ADR_FLAGS: begin
          // Writing one leaves the flag alone; only a zero clears it.
          if (!wb_dat_i[acc_pkg::FLG_DONE_BIT]) begin
            nxt_st.flag = 1'b0;
          end
        end
        acc_pkg::ADR_ENABLES: nxt_st.ien = wb_dat_i[acc_pkg::ENA_IRQ_BIT];
        default: ;  // Unmapped writes are acknowledged and dropped.
      endcase
    end

    // Settings move into effect only on a converter clock tick, so the
    // control path behaves as if it ran on the chosen clock; with a slow
    // RC clock this adds delay after a write.
    if (half_tick) begin
      nxt_st.a_csrc = st_ff.csrc;
      nxt_st.a_cdiv = st_ff.cdiv;
      if (!st_ff.busy) begin
        // Mux and references never change in the middle of a conversion.
        nxt_st.a_src  = decode_channel(st_ff.chan);
        nxt_st.a_pref = decode_pref(st_ff.pref);
        nxt_st.a_nref = st_ff.nref;
      end
    end

    // Conversion sequencing.
    if (st_ff.busy && !(st_ff.go && st_ff.on)) begin
      // Go cleared or module off: abandon the partial conversion.
      nxt_st.busy = 1'b0;
      nxt_st.hcnt = 5'h00;
    end else if (!st_ff.busy && st_ff.go && st_ff.on && half_tick) begin
      nxt_st.busy = 1'b1;
      nxt_st.hcnt = 5'h00;
    end else if (st_ff.busy && half_tick) begin
      if (st_ff.hcnt == acc_pkg::HALF_PERIODS - 5'h01) begin
        // Completion after 23 half periods.
        nxt_st.busy = 1'b0;
        nxt_st.hcnt = 5'h00;
        nxt_st.done = 1'b1;
        if (!st_ff.cont && !(bus_wr && wb_adr_i == acc_pkg::ADR_CONTROL)) begin
          nxt_st.go = 1'b0;
        end
        // Set wins over a same-cycle software clear.
        nxt_st.flag = 1'b1;
      end else begin
        nxt_st.hcnt   = st_ff.hcnt + 5'h01;
        // Every second half period resolves one bit.
        nxt_st.strobe = st_ff.hcnt[0];
      end
    end

    // Turning the module off always drops go.
    if (!nxt_st.on) begin
      nxt_st.go = 1'b0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff        <= '0;
      st_ff.chan   <= acc_pkg::RST_CHANNEL;
      st_ff.pref   <= acc_pkg::RST_PREF;
      st_ff.csrc   <= acc_pkg::RST_CSRC;
      st_ff.cdiv   <= acc_pkg::RST_CDIV;
      st_ff.a_pref <= decode_pref(acc_pkg::RST_PREF);
      st_ff.a_csrc <= acc_pkg::RST_CSRC;
      st_ff.a_cdiv <= acc_pkg::RST_CDIV;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state record.
  assign wb_dat_o         = st_ff.rdat;
  assign wb_ack_o         = st_ff.ack;
  assign sampler_source_o = st_ff.a_src;
  assign pos_ref_sel_o    = st_ff.a_pref;
  assign neg_ref_ext_o    = st_ff.a_nref;
  assign sample_hold_o    = st_ff.busy;
  assign bit_strobe_o     = st_ff.strobe;
  assign bit_index_o      = st_ff.hcnt[4:1];
  assign conv_done_o      = st_ff.done;
  // Request only while enabled; the flag itself is set regardless.
  assign conv_irq_o       = st_ff.flag && st_ff.ien;

endmodule

`default_nettype wire

// ---- bench/acc_top_chk.sv ----
// Concurrent checks on the converter control block ports, bound to its top.
`timescale 1ns/100ps
`default_nettype none
module acc_top_chk #(
  parameter int NUM_PINS = 35  // Same pin count as the block.
) (
  // Clock and reset.
  input wire logic                clk_i,
  input wire logic                rst_i,
  // Bus.
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  // Analog control.
  input wire logic [NUM_PINS+3:0] sampler_source_o,
  input wire logic [4:0]          pos_ref_sel_o,
  input wire logic                sample_hold_o,
  input wire logic                bit_strobe_o,
  input wire logic [3:0]          bit_index_o,
  input wire logic                conv_done_o,
  input wire logic                conv_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] nstrobe_ff;   // Strobes seen in the running conversion.
  logic [4:0] nxt_nstrobe;  // Next strobe count.
  // The count clears while idle, so an aborted run never leaks into the next one.
  always_comb begin
    nxt_nstrobe = sample_hold_o ? nstrobe_ff + {4'h0, bit_strobe_o} : 5'h00;
  end
  // Register the strobe count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nstrobe_ff <= 5'h00;
    end else begin
      nstrobe_ff <= nxt_nstrobe;
    end
  end
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  chk_rd_unmapped: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  chk_src_onehot: assert property ($onehot0(sampler_source_o))
    else $error("more than one source connected");
  chk_pref_onehot: assert property ($onehot(pos_ref_sel_o))
    else $error("positive reference not exactly one source");
  chk_done_closes: assert property (conv_done_o |-> !sample_hold_o && $past(sample_hold_o))
    else $error("done pulse without a finished conversion");
  chk_strobe_count: assert property (conv_done_o |-> nstrobe_ff == 5'h0B)
    else $error("conversion did not hold eleven bit strobes");
  chk_strobe_busy: assert property (bit_strobe_o |-> sample_hold_o)
    else $error("bit strobe outside conversion");
  chk_irq_holds: assert property (
    conv_irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> conv_irq_o)
    else $error("interrupt dropped without a write");
  chk_idx_idle: assert property (
    !sample_hold_o && !$past(sample_hold_o) |-> bit_index_o == 4'h0)
    else $error("bit index not zero while idle");
  cover property (conv_done_o);
  cover property (conv_irq_o);
  cover property (sample_hold_o && bit_strobe_o);
endmodule
bind acc_top acc_top_chk #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sampler_source_o(sampler_source_o), .pos_ref_sel_o(pos_ref_sel_o),
  .sample_hold_o(sample_hold_o), .bit_strobe_o(bit_strobe_o),
  .bit_index_o(bit_index_o), .conv_done_o(conv_done_o), .conv_irq_o(conv_irq_o));
`default_nettype wire

// ---- bench/acc_analog_model.sv ----
// Far side model: RC oscillator and the analog multiplexer watching the source lines.
`timescale 1ns/100ps
`default_nettype none
module acc_analog_model #(
  parameter int NUM_PINS = 35  // Pins behind the multiplexer.
) (
  // Controls from the bench.
  input wire logic                run_i,
  // Lines from the block.
  input wire logic [NUM_PINS+3:0] src_i,
  input wire logic                sh_i,
  // Outputs.
  output logic                    rc_clk_o,
  output int                      sel_o,
  output logic                    bad_o
);
  // The oscillator stands still when stopped, so stalled settings can be seen.
  initial begin
    rc_clk_o = 1'b0;
    forever begin
      #87.3;
      if (run_i) begin
        rc_clk_o = ~rc_clk_o;
      end
    end
  end
  // Every pin behind the multiplexer is taken as analog with its driver off.
  // Index of the connected source, minus one when the input is open.
  always_comb begin
    sel_o = -1;
    for (int k = 0; k < NUM_PINS + 4; k++) begin
      if (src_i[k]) begin
        sel_o = k;
      end
    end
  end
  // A source that moves during sampling would corrupt the sample.
  initial bad_o = 1'b0;
  always @(src_i) begin
    if (sh_i) begin
      bad_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/acc_top_test.sv ----
// Self-checking testbench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module acc_top_test;
  localparam int NP = 35;  // Pins on the large package.
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rd, d, wdo;
  logic ack, nref, sh, bs, done, irq, rc, bad;
  logic [NP+3:0] src;
  logic [4:0] pref;
  logic [3:0] idx;
  int err_total = 0, samples_checked = 0, seed = 17220, cyc_n = 0;
  int busy_n, strobes, dones, n, i, code, sel_idx, nb;
  int divs[4] = '{0, 1, 5, 63};
  always #25 clk_i = ~clk_i;
  acc_top #(.NUM_PINS(NP)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo),
    .wb_ack_o(ack), .rc_clk_i(rc), .sampler_source_o(src), .pos_ref_sel_o(pref),
    .neg_ref_ext_o(nref), .sample_hold_o(sh), .bit_strobe_o(bs), .bit_index_o(idx),
    .conv_done_o(done), .conv_irq_o(irq));
  acc_analog_model #(.NUM_PINS(NP)) u_far (.run_i(run), .src_i(src), .sh_i(sh),
    .rc_clk_o(rc), .sel_o(sel_idx), .bad_o(bad));
  // Expected source lines: pins low, internal sources above them, reserved open.
  function automatic logic [NP+3:0] exp_src(input int c);
    exp_src = '0;
    if (c < NP) exp_src[c] = 1'b1;
    else if (c >= 60) exp_src[NP + 63 - c] = 1'b1;
  endfunction
  // Counts, with a ceiling on the run as a whole.
  always @(posedge clk_i) begin
    if (sh === 1'b1) busy_n++;
    if (sh !== 1'b1) nb = 0;
    if (bs === 1'b1) begin
      strobes++;
      nb++;
      cmp("bit index", nb, idx);
    end
    if (done === 1'b1) dones++;
    cyc_n++;
    if (cyc_n > 40000) begin
      err_total++;
      results();
    end
  end
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (e !== g) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_cnt(input string nm, input int e, input int g);
    samples_checked++;
    if (e != g) begin
      err_total++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= v;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = wdo;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wait_done(input int lim);
    n = 0;
    while (dones < 1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    cmp_cnt("done seen", 1, dones);
  endtask
  // One conversion; ticks land every div plus one cycles.
  task automatic conv(input int dv, input logic [31:0] clk_code);
    wb(1, acc_pkg::ADR_CLKSEL, clk_code);
    wb(1, acc_pkg::ADR_CONTROL, 32'h0000_0001);
    busy_n = 0; strobes = 0; dones = 0;
    wb(1, acc_pkg::ADR_CONTROL, 32'h0000_0003);
    wait_done(4000);
    if (dv >= 0) cmp_cnt("busy cycles", 23 * (dv + 1), busy_n);
    cmp_cnt("strobes", 11, strobes);
    wb(0, acc_pkg::ADR_CONTROL, 0);
    cmp("go cleared", 1, rd);
    wb(0, acc_pkg::ADR_FLAGS, 0);
    cmp("flag", 1, rd);
  endtask
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wb(0, 8'(i * 4), 0);
      cmp("reset read", 0, rd);
    end
    cmp("pref reset", 5'h01, pref);
    for (i = 0; i < 80; i++) begin
      d = $random(seed);
      code = (i < 64) ? i : int'(d[5:0]);
      wb(1, acc_pkg::ADR_CHANNEL, {d[31:6], 6'(code)});
      repeat (3) @(posedge clk_i);  // Settling wait after a channel change.
      cmp("source", exp_src(code), src);
      wb(0, acc_pkg::ADR_CHANNEL, 0);
      cmp("channel read", code, rd);
    end
    for (i = 0; i < 16; i++) begin
      wb(1, acc_pkg::ADR_REFSEL, {27'h0, i[3], 1'b0, i[2:0]});
      repeat (3) @(posedge clk_i);
      cmp("pos ref", (i % 8 < 5) ? 5'h01 << (i % 8) : 5'h01, pref);
      cmp("neg ref", i[3], nref);
    end
    for (i = 0; i < 4; i++) conv(divs[i], divs[i]);
    wb(1, acc_pkg::ADR_ENABLES, 0);
    @(posedge clk_i);
    cmp("irq masked", 0, irq);
    wb(1, acc_pkg::ADR_ENABLES, 1);
    @(posedge clk_i);
    cmp("irq enabled", 1, irq);
    wb(1, acc_pkg::ADR_FLAGS, 1);
    repeat (20) @(posedge clk_i);
    cmp("flag kept", 1, irq);
    wb(1, acc_pkg::ADR_FLAGS, 0);
    @(posedge clk_i);
    cmp("irq cleared", 0, irq);
    wb(1, acc_pkg::ADR_CLKSEL, 0);
    wb(1, acc_pkg::ADR_CONTROL, 0);
    busy_n = 0;
    wb(1, acc_pkg::ADR_CONTROL, 32'h0000_0002);
    repeat (50) @(posedge clk_i);
    cmp_cnt("go while off", 0, busy_n);
    wb(1, acc_pkg::ADR_CONTROL, 1);
    dones = 0;
    wb(1, acc_pkg::ADR_CONTROL, 32'h0000_0007);
    repeat (60) @(posedge clk_i);
    cmp_cnt("continuous runs", 2, dones);
    wb(0, acc_pkg::ADR_CONTROL, 0);
    cmp("go kept", 7, rd);
    wb(1, acc_pkg::ADR_CONTROL, 1);
    repeat (3) @(posedge clk_i);
    dones = 0;
    repeat (40) @(posedge clk_i);
    cmp_cnt("abort", 0, dones);
    run <= 1'b1;
    conv(-1, 32'h0000_0080);
    wb(0, acc_pkg::ADR_STATUS, 0);
    cmp("rc in use", 1, rd[8]);
    run <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1, acc_pkg::ADR_CHANNEL, acc_pkg::CH_GND);
    wb(1, acc_pkg::ADR_CHANNEL, 7);
    repeat (20) @(posedge clk_i);
    cmp("stalled source", exp_src(code), src);
    run <= 1'b1;
    repeat (20) @(posedge clk_i);
    cmp("rc source", exp_src(7), src);
    cmp_cnt("far side pin", 7, sel_idx);
    cmp("steady sample", 0, bad);
    // Reset in the middle of a conversion must stop it and clear control.
    wb(1, acc_pkg::ADR_CONTROL, 32'h0000_0003);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, acc_pkg::ADR_CONTROL, 0);
    cmp("control after reset", 0, rd);
    cmp("hold after reset", 0, sh);
    results();
  end
endmodule
`default_nettype wire
